// ==== rtl/qprc_pkg.sv ====
package qprc_pkg;

	localparam logic [11:0] ADDR_CONTROL   = 12'h000;
	localparam logic [11:0] ADDR_FILTER    = 12'h004;
	localparam logic [11:0] ADDR_POSITION  = 12'h008;
	localparam logic [11:0] ADDR_MAXIMUM   = 12'h00C;

	localparam logic [15:0] RST_CONTROL    = 16'h0000;
	localparam logic [15:0] RST_POSITION   = 16'h0000;
	localparam logic [15:0] RST_MAXIMUM    = 16'h1111;
	localparam logic [15:0] RST_FILTER     = 16'h0000;

	localparam logic [15:0] MASK_CONTROL   = 16'hBFFF;
	localparam logic [15:0] MASK_FILTER    = 16'h07F0;

	localparam int BIT_COUNT_ERROR  = 15;
	localparam int BIT_STOP_IDLE    = 13;
	localparam int BIT_INDEX_STATE  = 12;
	localparam int BIT_DIRECTION    = 11;
	localparam int BIT_MODE_LSB     = 8;
	localparam int BIT_SWAP         = 7;
	localparam int BIT_DIR_OUT_EN   = 6;
	localparam int BIT_TIMER_CLOCK  = 1;
	localparam int BIT_DIR_SOURCE   = 0;

	localparam logic [2:0] MODE_TIMER        = 3'h1;
	localparam logic [2:0] MODE_INDEX_X2     = 3'h4;
	localparam logic [2:0] MODE_MATCH_X2     = 3'h5;
	localparam logic [2:0] MODE_INDEX_X4     = 3'h6;
	localparam logic [2:0] MODE_MATCH_X4     = 3'h7;

endpackage

// ==== rtl/qprc_top.sv ====
module qprc_top
(
	// clock, reset, enable
	input  wire logic        i_sys_clk,
	input  wire logic        i_rstn,
	input  wire logic        i_clk_en,
	// power state
	input  wire logic        i_sleep,
	input  wire logic        i_idle,
	// ahb-lite slave
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic      [31:0] o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	// encoder pins
	input  wire logic        i_phase_a_input,
	input  wire logic        i_phase_b_input,
	input  wire logic        i_index_input,
	output logic             o_direction_output,
	output logic             o_direction_output_oe
);

	logic [15:0] control_r;
	logic [15:0] filter_r;
	logic [15:0] position_r;
	logic [15:0] maximum_r;
	logic [2:0]  a_sync_r;
	logic [2:0]  b_sync_r;
	logic [2:0]  x_sync_r;
	logic        a_r;
	logic        b_r;
	logic        x_r;
	logic        dir_r;
	logic        frozen;
	logic        run;
	logic [2:0]  mode;
	logic        is_match;
	logic        is_index;
	logic        is_quad;
	logic        a_in;
	logic        b_in;
	logic        a_chg;
	logic        b_chg;
	logic        up_q;
	logic        step_q;
	logic        tmr_step;
	logic        tmr_up;
	logic        x_rise;
	logic [15:0] position_nxt;
	logic        dir_nxt;
	logic        err_nxt;
	logic        ph_wr;
	logic [11:0] ph_addr;
	logic        wr_ctl;
	logic        wr_flt;
	logic        wr_pos;
	logic        wr_max;

	////////////////////////////////////////////////////////////////////////////
	// power state

	assign frozen = i_sleep | (i_idle & control_r[qprc_pkg::BIT_STOP_IDLE]);
	assign run    = i_clk_en & ~frozen;
	assign mode   = control_r[qprc_pkg::BIT_MODE_LSB +: 3];
	assign is_match = (mode == qprc_pkg::MODE_MATCH_X4) | (mode == qprc_pkg::MODE_MATCH_X2);
	assign is_index = (mode == qprc_pkg::MODE_INDEX_X4) | (mode == qprc_pkg::MODE_INDEX_X2);
	assign is_quad  = is_match | is_index;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: a change counts once stages two and three agree

	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			a_sync_r <= 3'h0;
			b_sync_r <= 3'h0;
			x_sync_r <= 3'h0;
		end
		else if (run)
		begin
			a_sync_r <= {a_sync_r[1:0], i_phase_a_input};
			b_sync_r <= {b_sync_r[1:0], i_phase_b_input};
			x_sync_r <= {x_sync_r[1:0], i_index_input};
		end
	end

	// last accepted pin levels; held while frozen so the first edge after wake
	// is judged against the pre-sleep state
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			a_r <= 1'b0;
			b_r <= 1'b0;
			x_r <= 1'b0;
		end
		else if (run)
		begin
			if (a_sync_r[2] == a_sync_r[1])
				a_r <= a_sync_r[2];
			if (b_sync_r[2] == b_sync_r[1])
				b_r <= b_sync_r[2];
			if (x_sync_r[2] == x_sync_r[1])
				x_r <= x_sync_r[2];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// decoder and counter

	always_comb
	begin
		logic sa;
		logic sb;
		sa = 1'b0;
		sb = 1'b0;
		sa = (a_sync_r[2] == a_sync_r[1]) ? a_sync_r[2] : a_r;
		sb = (b_sync_r[2] == b_sync_r[1]) ? b_sync_r[2] : b_r;
		a_in  = control_r[qprc_pkg::BIT_SWAP] ? sb : sa;
		b_in  = control_r[qprc_pkg::BIT_SWAP] ? sa : sb;
		a_chg = control_r[qprc_pkg::BIT_SWAP] ? (sb != b_r) : (sa != a_r);
		b_chg = control_r[qprc_pkg::BIT_SWAP] ? (sa != a_r) : (sb != b_r);
	end

	// x4 counts every edge unless both phases change at once, x2 only phase a edges
	assign up_q   = a_chg ? (a_in != b_in) : (a_in == b_in);
	assign step_q = is_quad & (a_chg | (b_chg & mode[1]) ? 1'b1 : 1'b0)
		& (a_chg ^ b_chg);
	assign tmr_step = (mode == qprc_pkg::MODE_TIMER)
		& (control_r[qprc_pkg::BIT_TIMER_CLOCK] ? (a_chg & a_in) : 1'b1);
	assign tmr_up = control_r[qprc_pkg::BIT_DIR_SOURCE] ? b_in
		: control_r[qprc_pkg::BIT_DIRECTION];
	assign x_rise = is_index & (x_sync_r[2] == x_sync_r[1]) & x_sync_r[2] & ~x_r;

	always_comb
	begin
		position_nxt = position_r;
		dir_nxt      = dir_r;
		err_nxt      = 1'b0;
		if (step_q)
		begin
			dir_nxt = up_q;
			if (x_rise)
				position_nxt = 16'h0000;
			else if (up_q)
				position_nxt = (is_match && position_r == maximum_r) ? 16'h0000
					: position_r + 16'h0001;
			else
				position_nxt = (is_match && position_r == 16'h0000) ? maximum_r
					: position_r - 16'h0001;
		end
		else if (tmr_step)
		begin
			dir_nxt = tmr_up;
			if (position_r == maximum_r)
				position_nxt = 16'h0000;
			else
				position_nxt = tmr_up ? position_r + 16'h0001 : position_r - 16'h0001;
		end
		if (a_chg && b_chg && is_quad)
			err_nxt = 1'b1;
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			dir_r <= 1'b0;
		else if (run)
			dir_r <= dir_nxt;
	end

	// software write wins only when the counter does not change the count this cycle
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			position_r <= qprc_pkg::RST_POSITION;
		else if (i_clk_en)
		begin
			if (run && position_nxt != position_r)
				position_r <= position_nxt;
			else if (wr_pos)
				position_r <= i_hwdata[15:0];
		end
	end

	assign o_direction_output    = dir_r;
	assign o_direction_output_oe = is_quad & control_r[qprc_pkg::BIT_DIR_OUT_EN];

	////////////////////////////////////////////////////////////////////////////
	// ahb-lite slave, zero wait states

	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			ph_wr   <= 1'b0;
			ph_addr <= 12'h000;
		end
		else if (i_clk_en && i_hready)
		begin
			ph_wr   <= i_hsel & i_htrans[1] & i_hwrite;
			ph_addr <= i_haddr[11:0];
		end
	end

	assign wr_ctl = i_clk_en & ph_wr & (ph_addr == qprc_pkg::ADDR_CONTROL);
	assign wr_flt = i_clk_en & ph_wr & (ph_addr == qprc_pkg::ADDR_FILTER);
	assign wr_pos = i_clk_en & ph_wr & (ph_addr == qprc_pkg::ADDR_POSITION);
	assign wr_max = i_clk_en & ph_wr & (ph_addr == qprc_pkg::ADDR_MAXIMUM);

	// sleep has no effect on the configuration; only software, the error and the index pin level (index state bit) set it
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			control_r <= qprc_pkg::RST_CONTROL;
		else if (i_clk_en)
		begin
			if (wr_ctl)
				control_r <= i_hwdata[15:0] & qprc_pkg::MASK_CONTROL;
			control_r[qprc_pkg::BIT_INDEX_STATE] <= x_r;
			if (run && err_nxt)
				control_r[qprc_pkg::BIT_COUNT_ERROR] <= 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			filter_r <= qprc_pkg::RST_FILTER;
		else if (wr_flt)
			filter_r <= i_hwdata[15:0] & qprc_pkg::MASK_FILTER;
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			maximum_r <= qprc_pkg::RST_MAXIMUM;
		else if (wr_max)
			maximum_r <= i_hwdata[15:0];
	end

	always_comb
	begin
		unique case (ph_addr)
			qprc_pkg::ADDR_CONTROL:  o_hrdata = {16'h0000, control_r};
			qprc_pkg::ADDR_FILTER:   o_hrdata = {16'h0000, filter_r};
			qprc_pkg::ADDR_POSITION: o_hrdata = {16'h0000, position_r};
			qprc_pkg::ADDR_MAXIMUM:  o_hrdata = {16'h0000, maximum_r};
			default:                 o_hrdata = 32'h0000_0000;
		endcase
	end

	assign o_hreadyout = 1'b1;
	assign o_hresp     = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// checks

	AST_FROZEN_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(frozen && $past(frozen) && !$past(wr_pos)) |-> $stable(position_r))
		else $error("count moved while frozen");
	AST_PINS_IGNORED: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		frozen |=> $stable(a_r) && $stable(b_r) && $stable(x_r))
		else $error("pin state changed while frozen");
	AST_CTL_KEPT: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(i_sleep && !wr_ctl) |=> ($past(control_r[10:0]) == control_r[10:0]))
		else $error("control changed in sleep");
	AST_TIMER_HALT: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(i_sleep && mode == qprc_pkg::MODE_TIMER && !wr_pos) |=> $stable(position_r))
		else $error("timer counted in sleep");
	AST_IDLE_STOP: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(i_idle && control_r[qprc_pkg::BIT_STOP_IDLE]) |-> frozen)
		else $error("idle did not freeze");
	AST_IDLE_RUN: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(i_idle && !i_sleep && !control_r[qprc_pkg::BIT_STOP_IDLE]) |-> !frozen)
		else $error("idle froze without stop bit");
	AST_OFF_MODE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(!is_quad && mode != qprc_pkg::MODE_TIMER && !wr_pos) |=> $stable(position_r))
		else $error("count moved with module off");
	AST_RD_UPPER: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		o_hrdata[31:16] == 16'h0000 && o_hrdata[14] == 1'b0)
		else $error("unimplemented bits read nonzero");


	// decoder and counter steps
	AST_QUAD_UP: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(run && step_q && up_q && !x_rise && !(is_match && position_r == maximum_r))
		|=> position_r == $past(position_r) + 16'h0001) else $error("quadrature up step lost");
	AST_QUAD_DOWN: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(run && step_q && !up_q && !x_rise && !(is_match && position_r == 16'h0000))
		|=> position_r == $past(position_r) - 16'h0001) else $error("quadrature down step lost");
	AST_MATCH_WRAP: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(run && step_q && up_q && !x_rise && is_match && position_r == maximum_r)
		|=> position_r == 16'h0000) else $error("no wrap at maximum");
	AST_MATCH_UNDER: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(run && step_q && !up_q && !x_rise && is_match && position_r == 16'h0000)
		|=> position_r == $past(maximum_r)) else $error("no reload at zero");
	AST_INDEX_CLEAR: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(run && step_q && x_rise) |=> position_r == 16'h0000)
		else $error("index did not clear count");
	AST_X2_B_IGNORED: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(is_quad && !mode[1] && b_chg && !a_chg) |-> !step_q)
		else $error("x2 mode counted a phase b edge");
	AST_ERR_SET: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(run && err_nxt) |=> control_r[qprc_pkg::BIT_COUNT_ERROR])
		else $error("count error flag not set");
	AST_OE_OFF: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		!is_quad |-> !o_direction_output_oe)
		else $error("direction pin driven outside decoder modes");

	// power saving
	AST_SYNC_HELD: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		!run |=> $stable(a_sync_r) && $stable(b_sync_r) && $stable(x_sync_r))
		else $error("pin sampling ran while frozen");
	AST_DIR_HELD: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		frozen |=> $stable(dir_r))
		else $error("direction moved while frozen");

	// timer
	AST_TMR_UP: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(run && tmr_step && tmr_up && position_r != maximum_r)
		|=> position_r == $past(position_r) + 16'h0001) else $error("timer step lost");
	AST_TMR_MATCH: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(run && tmr_step && position_r == maximum_r) |=> position_r == 16'h0000)
		else $error("timer did not restart on match");
	AST_TMR_EXT_EDGE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(mode == qprc_pkg::MODE_TIMER && control_r[qprc_pkg::BIT_TIMER_CLOCK])
		|-> (tmr_step == (a_chg && a_in))) else $error("timer step without phase a rise");

	// register bus
	AST_RESP_OKAY: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		o_hresp == 1'b0 && o_hreadyout == 1'b1)
		else $error("bus response not okay");
	AST_MAX_HELD: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		!wr_max |=> $stable(maximum_r))
		else $error("maximum count changed without a write");

	COV_SLEEP: cover property (@(posedge i_sys_clk) disable iff (!i_rstn) i_sleep ##1 !i_sleep);
	COV_IDLE_STOP: cover property (@(posedge i_sys_clk) disable iff (!i_rstn) (i_idle && frozen));
	COV_QUAD_STEP: cover property (@(posedge i_sys_clk) disable iff (!i_rstn) (run && step_q));
	COV_TIMER: cover property (@(posedge i_sys_clk) disable iff (!i_rstn) (run && tmr_step));

endmodule

// ==== tb/qprc_enc_model.sv ====
module qprc_enc_model
(
	// clock
	input  wire logic i_sys_clk,
	// step requests from the bench
	input  wire logic i_step,
	input  wire logic i_fwd,
	input  wire logic i_index,
	// encoder outputs
	output logic      o_phase_a,
	output logic      o_phase_b,
	output logic      o_index
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [1:0] pos_r;

	initial pos_r = 2'h0;

	// one phase changes per step: forward order is 00, 10, 11, 01
	always_ff @(posedge i_sys_clk)
	begin
		if (i_step)
			pos_r <= i_fwd ? pos_r + 2'h1 : pos_r - 2'h1;
	end

	assign o_phase_a = (pos_r == 2'h1) || (pos_r == 2'h2);
	assign o_phase_b = pos_r[1];
	assign o_index   = i_index;
endmodule

// ==== tb/qprc_top_tb_top.sv ====
module qprc_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	logic        i_sys_clk, i_rstn, i_sleep, i_idle, i_hsel, i_hwrite;
	logic        step, fwd, index, pha, phb, idx, hready, o_hresp, dir, oe;
	logic [1:0]  i_htrans;
	logic [31:0] i_haddr, i_hwdata, o_hrdata;
	// bus answer as it stands before each rising edge, free of update races
	logic        rdy_s;
	logic [31:0] rdata_s;
	int          err_total, n_compared;

	qprc_top dut_u (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_clk_en(1'b1),
		.i_sleep(i_sleep), .i_idle(i_idle), .i_hsel(i_hsel), .i_haddr(i_haddr),
		.i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata),
		.i_hready(hready), .o_hrdata(o_hrdata), .o_hreadyout(hready), .o_hresp(o_hresp),
		.i_phase_a_input(pha), .i_phase_b_input(phb), .i_index_input(idx),
		.o_direction_output(dir), .o_direction_output_oe(oe));

	qprc_enc_model enc_u (.i_sys_clk(i_sys_clk), .i_step(step), .i_fwd(fwd),
		.i_index(index), .o_phase_a(pha), .o_phase_b(phb), .o_index(idx));

	////////////////////////////////////////////////////////////////////////////////
	task test_done;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task wait_rdy;
		int k;
		k = 0;
		do
		begin
			@(posedge i_sys_clk);
			k++;
		end
		while (rdy_s !== 1'b1 && k < 16);
		if (rdy_s !== 1'b1)
		begin
			err_total++;
			test_done;
		end
	endtask

	// one single word transfer: address phase, then data phase
	task bus(input logic [11:0] a, input logic w, input logic [15:0] d, output logic [31:0] r);
		i_hsel <= 1'b1;
		i_haddr <= {20'h00000, a};
		i_htrans <= 2'h2;
		i_hwrite <= w;
		wait_rdy;
		i_hsel <= 1'b0;
		i_htrans <= 2'h0;
		i_hwdata <= {16'h0000, d};
		wait_rdy;
		r = rdata_s;
	endtask

	task wr(input logic [11:0] a, input logic [15:0] d);
		logic [31:0] r;
		bus(a, 1'b1, d, r);
	endtask

	task rd(input logic [11:0] a, input logic [15:0] e);
		logic [31:0] r;
		bus(a, 1'b0, 16'h0000, r);
		chk(r, {16'h0000, e});
		chk({31'h0, o_hresp}, 32'h0);
	endtask

	// one encoder step, then time for the pin synchronisers and the counter
	task move(input logic f);
		step <= 1'b1;
		fwd <= f;
		@(posedge i_sys_clk);
		step <= 1'b0;
		repeat (8) @(posedge i_sys_clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task t_reset_values;
		rd(qprc_pkg::ADDR_CONTROL, 16'h0000);
		rd(qprc_pkg::ADDR_POSITION, 16'h0000);
		rd(qprc_pkg::ADDR_MAXIMUM, 16'h1111);
		wr(qprc_pkg::ADDR_FILTER, 16'hFFFF);
		rd(qprc_pkg::ADDR_FILTER, 16'h07F0);
		rd(12'h010, 16'h0000);
	endtask

	task t_count;
		wr(qprc_pkg::ADDR_CONTROL, 16'h6740);
		rd(qprc_pkg::ADDR_CONTROL, 16'h2740);
		repeat (3) move(1'b1);
		rd(qprc_pkg::ADDR_POSITION, 16'h0003);
		chk({30'h0, oe, dir}, 32'h3);
		move(1'b0);
		rd(qprc_pkg::ADDR_POSITION, 16'h0002);
		chk({30'h0, oe, dir}, 32'h2);
	endtask

	task t_sleep;
		i_sleep <= 1'b1;
		index <= 1'b1;
		move(1'b0);
		rd(qprc_pkg::ADDR_POSITION, 16'h0002);
		rd(qprc_pkg::ADDR_CONTROL, 16'h2740);
		move(1'b1);
		index <= 1'b0;
		i_sleep <= 1'b0;
		move(1'b1);
		rd(qprc_pkg::ADDR_POSITION, 16'h0003);
	endtask

	task t_idle;
		i_idle <= 1'b1;
		move(1'b1);
		rd(qprc_pkg::ADDR_POSITION, 16'h0003);
		move(1'b0);
		i_idle <= 1'b0;
		wr(qprc_pkg::ADDR_CONTROL, 16'h0740);
		i_idle <= 1'b1;
		move(1'b1);
		rd(qprc_pkg::ADDR_POSITION, 16'h0004);
		i_idle <= 1'b0;
	endtask

	// each forward and back pair gives one rising edge on phase A
	task t_timer;
		wr(qprc_pkg::ADDR_CONTROL, 16'h0902);
		wr(qprc_pkg::ADDR_POSITION, 16'h0000);
		repeat (3)
		begin
			move(1'b1);
			move(1'b0);
		end
		rd(qprc_pkg::ADDR_POSITION, 16'h0003);
		i_sleep <= 1'b1;
		repeat (2)
		begin
			move(1'b1);
			move(1'b0);
		end
		rd(qprc_pkg::ADDR_POSITION, 16'h0003);
		i_sleep <= 1'b0;
	endtask

	task t_reset;
		wr(qprc_pkg::ADDR_MAXIMUM, 16'h00FF);
		rd(qprc_pkg::ADDR_MAXIMUM, 16'h00FF);
		i_rstn <= 1'b0;
		repeat (3) @(posedge i_sys_clk);
		i_rstn <= 1'b1;
		@(posedge i_sys_clk);
		rd(qprc_pkg::ADDR_CONTROL, 16'h0000);
		rd(qprc_pkg::ADDR_POSITION, 16'h0000);
		rd(qprc_pkg::ADDR_MAXIMUM, 16'h1111);
		chk({30'h0, oe, dir}, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		i_sys_clk = 1'b0;
		forever #20 i_sys_clk = ~i_sys_clk;
	end

	always @(negedge i_sys_clk)
	begin
		rdy_s   = hready;
		rdata_s = o_hrdata;
	end

	initial
	begin
		#2000000;
		err_total++;
		test_done;
	end

	initial
	begin
		{i_rstn, i_sleep, i_idle, i_hsel, i_hwrite, step, fwd, index} = 8'h00;
		i_htrans = 2'h0;
		i_haddr = 32'h00000000;
		i_hwdata = 32'h00000000;
		err_total = 0;
		n_compared = 0;
		repeat (10) @(posedge i_sys_clk);
		i_rstn <= 1'b1;
		@(posedge i_sys_clk);
		t_reset_values;
		t_count;
		t_sleep;
		t_idle;
		t_timer;
		t_reset;
		test_done;
	end
endmodule
